//--- hdl/pmcsr_pkg.sv
// package: constants and types of the power mode control/status registers
package pmcsr_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [31:0] PMCSR_BASE_ADDR    = 32'h4000_7000;
  localparam logic [7:0]  PMCSR_CTL_OFFSET   = 8'h00;
  localparam logic [7:0]  PMCSR_CS_OFFSET    = 8'h04;
  localparam logic [31:0] PMCSR_CTL_RESET    = 32'h0000_4000;
  localparam logic [31:0] PMCSR_CS_RESET     = 32'h0000_0000;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int PMCSR_BKP_WEN_BIT   = 8;
  localparam int PMCSR_THR_LSB       = 5;
  localparam int PMCSR_THR_MSB       = 7;
  localparam int PMCSR_DET_EN_BIT    = 4;
  localparam int PMCSR_STB_CLR_BIT   = 3;
  localparam int PMCSR_WUF_CLR_BIT   = 2;
  localparam int PMCSR_STB_SEL_BIT   = 1;
  localparam int PMCSR_REG_LP_BIT    = 0;
  // bit 14 is set in the reset value although it is reserved
  localparam int PMCSR_CTL_RSV14_BIT = 14;

  // ----------------------------------------------------------------
  // control and status register fields
  // ----------------------------------------------------------------
  localparam int PMCSR_WAKE_EN_BIT   = 8;
  localparam int PMCSR_DET_FLAG_BIT  = 2;
  localparam int PMCSR_STB_FLAG_BIT  = 1;
  localparam int PMCSR_WUF_BIT       = 0;

  // ----------------------------------------------------------------
  // bus access sizes
  // ----------------------------------------------------------------
  localparam logic [1:0] PMCSR_SIZE_BYTE = 2'h0;
  localparam logic [1:0] PMCSR_SIZE_HALF = 2'h1;
  localparam logic [1:0] PMCSR_SIZE_WORD = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        sel;
    logic        write;
    logic [31:0] addr;
    logic [1:0]  size;
    logic [31:0] wdata;
  } pmcsr_bus_req_t;

  typedef struct packed {
    logic        ready;
    logic        error;
    logic [31:0] rdata;
  } pmcsr_bus_rsp_t;

  typedef struct packed {
    logic       backup_write_enable;
    logic [2:0] detector_threshold_sel;
    logic       detector_enable;
    logic       regulator_low_power;
    logic       enter_standby;
    logic       enter_deep_sleep;
    logic       core_reset;
  } pmcsr_power_ctl_t;

  typedef enum logic [2:0] {
    PMCSR_RUN   = 3'h1,
    PMCSR_DEEP  = 3'h2,
    PMCSR_STBY  = 3'h4
  } pmcsr_mode_t;

endpackage : pmcsr_pkg

//--- hdl/pmcsr_sync.sv
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/10ps
module pmcsr_sync (
  // clock and control
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic ce,
  // level in and out
  input  wire logic d_async,
  output logic      q_sync
);
  logic meta_q;

  // first flop is read by the second only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_q <= 1'b0;
      q_sync <= 1'b0;
    end else if (ce) begin
      meta_q <= d_async;
      q_sync <= meta_q;
    end
  end
endmodule : pmcsr_sync

//--- hdl/pmcsr_top.sv
// power mode control/status registers with standby sequencing
`timescale 1ns/10ps

module pmcsr_top
  import pmcsr_pkg::*;
(
  // clock, reset, enable
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  input  wire logic                       ce,
  // register bus
  input  wire pmcsr_pkg::pmcsr_bus_req_t  bus_req,
  output pmcsr_pkg::pmcsr_bus_rsp_t       bus_rsp,
  // core and system events
  input  wire logic                       core_deep_sleep_state,
  input  wire logic                       core_wfi,
  input  wire logic                       deep_sleep_wake,
  input  wire logic                       rtc_alarm,
  input  wire logic                       ext_wake_reset,
  // analog and pin inputs
  input  wire logic                       low_voltage_detector,
  input  wire logic                       wake_pin,
  // power controls
  output pmcsr_pkg::pmcsr_power_ctl_t     power_ctl,
  output logic                            wake_pin_pulldown
);
  import pmcsr_pkg::*;

  // ----------------------------------------------------------------
  // decoding
  // ----------------------------------------------------------------
  // returns offset hit when the upper address matches the base
  function automatic logic addr_hit(input logic [31:0] a, input logic [7:0] off);
    addr_hit = (a[31:8] == PMCSR_BASE_ADDR[31:8]) && (a[7:0] == off);
  endfunction : addr_hit

  // half-word and word are the only sizes accepted; byte and size 3 are refused
  function automatic logic size_ok(input logic [1:0] s);
    size_ok = (s == PMCSR_SIZE_HALF) || (s == PMCSR_SIZE_WORD);
  endfunction : size_ok

  logic        wr_ok;
  logic        hit_ctl;
  logic        hit_cs;
  logic        wr_ctl;
  logic        wr_cs;
  logic [31:0] wd;
  logic        upper_half;

  assign hit_ctl    = addr_hit({bus_req.addr[31:2], 2'h0}, PMCSR_CTL_OFFSET);
  assign hit_cs     = addr_hit({bus_req.addr[31:2], 2'h0}, PMCSR_CS_OFFSET);
  assign wr_ok      = bus_req.sel && bus_req.write && size_ok(bus_req.size);
  assign upper_half = (bus_req.size == PMCSR_SIZE_HALF) && bus_req.addr[1];
  // half-word write to the upper lane touches only reserved bits
  assign wd         = upper_half ? 32'h0000_0000 : bus_req.wdata;
  assign wr_ctl     = ce && wr_ok && hit_ctl && !upper_half;
  assign wr_cs      = ce && wr_ok && hit_cs && !upper_half;

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  logic det_s;
  logic pin_s;
  logic pin_prev_q;

  pmcsr_sync u_sync_det (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .d_async (low_voltage_detector),
    .q_sync  (det_s)
  );

  pmcsr_sync u_sync_pin (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .d_async (wake_pin),
    .q_sync  (pin_s)
  );

  // ----------------------------------------------------------------
  // power mode sequencer
  // ----------------------------------------------------------------
  pmcsr_mode_t mode_q;
  logic        wake_en_q;
  logic        wake_event;
  logic        stby_exit;

  // enable edge while pin high counts like a rising edge
  logic wake_en_prev_q;
  assign wake_event = wake_en_q && pin_s && (!pin_prev_q || !wake_en_prev_q);
  assign stby_exit  = (mode_q == PMCSR_STBY) &&
                      (wake_event || rtc_alarm || ext_wake_reset);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_prev_q     <= 1'b0;
      wake_en_prev_q <= 1'b0;
    end else if (ce) begin
      pin_prev_q     <= pin_s;
      wake_en_prev_q <= wake_en_q;
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic       bkp_wen_q;
  logic [2:0] thr_q;
  logic       det_en_q;
  logic       stb_sel_q;
  logic       reg_lp_q;

  // standby loses the core domain, so control reloads its reset value
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bkp_wen_q <= PMCSR_CTL_RESET[PMCSR_BKP_WEN_BIT];
      thr_q     <= PMCSR_CTL_RESET[PMCSR_THR_MSB:PMCSR_THR_LSB];
      det_en_q  <= PMCSR_CTL_RESET[PMCSR_DET_EN_BIT];
      stb_sel_q <= PMCSR_CTL_RESET[PMCSR_STB_SEL_BIT];
      reg_lp_q  <= PMCSR_CTL_RESET[PMCSR_REG_LP_BIT];
    end else if (ce) begin
      if (stby_exit) begin
        bkp_wen_q <= PMCSR_CTL_RESET[PMCSR_BKP_WEN_BIT];
        thr_q     <= PMCSR_CTL_RESET[PMCSR_THR_MSB:PMCSR_THR_LSB];
        det_en_q  <= PMCSR_CTL_RESET[PMCSR_DET_EN_BIT];
        stb_sel_q <= PMCSR_CTL_RESET[PMCSR_STB_SEL_BIT];
        reg_lp_q  <= PMCSR_CTL_RESET[PMCSR_REG_LP_BIT];
      end else if (wr_ctl) begin
        bkp_wen_q <= wd[PMCSR_BKP_WEN_BIT];
        thr_q     <= wd[PMCSR_THR_MSB:PMCSR_THR_LSB];
        det_en_q  <= wd[PMCSR_DET_EN_BIT];
        stb_sel_q <= wd[PMCSR_STB_SEL_BIT];
        reg_lp_q  <= wd[PMCSR_REG_LP_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // mode transitions
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_q <= PMCSR_RUN;
    end else if (ce) begin
      case (mode_q)
        PMCSR_RUN: begin
          if (core_deep_sleep_state && core_wfi) begin
            mode_q <= stb_sel_q ? PMCSR_STBY : PMCSR_DEEP;
          end
        end
        PMCSR_DEEP: begin
          if (deep_sleep_wake) begin
            mode_q <= PMCSR_RUN;
          end
        end
        PMCSR_STBY: begin
          if (stby_exit) begin
            mode_q <= PMCSR_RUN;
          end
        end
        default: mode_q <= PMCSR_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // control and status register
  // ----------------------------------------------------------------
  logic stb_flag_q;
  logic wuf_q;
  logic det_flag_q;
  logic det_active;

  assign det_active = det_en_q && (mode_q != PMCSR_STBY);

  // not touched by standby exit, only by rst and bus writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wake_en_q <= PMCSR_CS_RESET[PMCSR_WAKE_EN_BIT];
    end else if (ce && wr_cs) begin
      wake_en_q <= wd[PMCSR_WAKE_EN_BIT];
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stb_flag_q <= PMCSR_CS_RESET[PMCSR_STB_FLAG_BIT];
    end else if (ce) begin
      if (mode_q == PMCSR_STBY) begin
        stb_flag_q <= 1'b1;
      end else if (wr_ctl && wd[PMCSR_STB_CLR_BIT]) begin
        stb_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wuf_q <= PMCSR_CS_RESET[PMCSR_WUF_BIT];
    end else if (ce) begin
      if (wake_event || rtc_alarm) begin
        wuf_q <= 1'b1;
      end else if (wr_ctl && wd[PMCSR_WUF_CLR_BIT]) begin
        wuf_q <= 1'b0;
      end
    end
  end

  // comparator output is only meaningful while the detector runs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      det_flag_q <= PMCSR_CS_RESET[PMCSR_DET_FLAG_BIT];
    end else if (ce) begin
      det_flag_q <= det_active && det_s;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [31:0] ctl_rd;
  logic [31:0] cs_rd;
  logic [31:0] rd_word;

  always_comb begin
    ctl_rd = 32'h0000_0000;
    ctl_rd[PMCSR_CTL_RSV14_BIT]          = PMCSR_CTL_RESET[PMCSR_CTL_RSV14_BIT];
    ctl_rd[PMCSR_BKP_WEN_BIT]            = bkp_wen_q;
    ctl_rd[PMCSR_THR_MSB:PMCSR_THR_LSB]  = thr_q;
    ctl_rd[PMCSR_DET_EN_BIT]             = det_en_q;
    ctl_rd[PMCSR_STB_CLR_BIT]            = 1'b0;
    ctl_rd[PMCSR_WUF_CLR_BIT]            = 1'b0;
    ctl_rd[PMCSR_STB_SEL_BIT]            = stb_sel_q;
    ctl_rd[PMCSR_REG_LP_BIT]             = reg_lp_q;
    cs_rd = 32'h0000_0000;
    cs_rd[PMCSR_WAKE_EN_BIT]             = wake_en_q;
    cs_rd[PMCSR_DET_FLAG_BIT]            = det_flag_q;
    cs_rd[PMCSR_STB_FLAG_BIT]            = stb_flag_q;
    cs_rd[PMCSR_WUF_BIT]                 = wuf_q;
    rd_word = hit_ctl ? ctl_rd : (hit_cs ? cs_rd : 32'h0000_0000);
    // upper half-word is returned in the low lane
    if (upper_half) begin
      rd_word = {16'h0000, rd_word[31:16]};
    end
  end

  // one-cycle answer; unmapped or byte access answers with error
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_rsp <= '0;
    end else if (ce) begin
      bus_rsp.ready <= bus_req.sel;
      bus_rsp.error <= bus_req.sel && !(size_ok(bus_req.size) && (hit_ctl || hit_cs));
      bus_rsp.rdata <= (bus_req.sel && !bus_req.write && size_ok(bus_req.size)) ?
                       rd_word : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // power control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      power_ctl         <= '0;
      wake_pin_pulldown <= 1'b0;
    end else if (ce) begin
      power_ctl.backup_write_enable    <= bkp_wen_q;
      power_ctl.detector_threshold_sel <= thr_q;
      power_ctl.detector_enable        <= det_active;
      power_ctl.regulator_low_power    <= reg_lp_q && (mode_q == PMCSR_DEEP);
      power_ctl.enter_standby          <= (mode_q == PMCSR_STBY);
      power_ctl.enter_deep_sleep       <= (mode_q == PMCSR_DEEP);
      power_ctl.core_reset             <= stby_exit;
      wake_pin_pulldown                <= wake_en_q;
    end
  end

endmodule : pmcsr_top

//--- verification/pmcsr_top_props.sv
// checker: port-level properties of the power mode registers
`timescale 1ns/10ps
module pmcsr_top_props
  import pmcsr_pkg::*;
(
  // clock and reset
  input wire logic                        ref_clk,
  input wire logic                        rst,
  input wire logic                        ce,
  // register bus
  input wire pmcsr_pkg::pmcsr_bus_req_t   bus_req,
  input wire pmcsr_pkg::pmcsr_bus_rsp_t   bus_rsp,
  // core and power
  input wire logic                        core_deep_sleep_state,
  input wire logic                        core_wfi,
  input wire pmcsr_pkg::pmcsr_power_ctl_t power_ctl,
  input wire logic                        wake_pin_pulldown
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic tk;
  logic rd_ctl;
  logic wr_ctl;
  logic wr_cs;
  assign tk = ce && bus_req.sel;
  assign rd_ctl = tk && !bus_req.write && bus_req.addr == PMCSR_BASE_ADDR
                  && bus_req.size != PMCSR_SIZE_BYTE;
  assign wr_ctl = tk && bus_req.write && bus_req.addr == PMCSR_BASE_ADDR
                  && bus_req.size != PMCSR_SIZE_BYTE;
  assign wr_cs = tk && bus_req.write && bus_req.addr == PMCSR_BASE_ADDR + 32'h4
                 && bus_req.size != PMCSR_SIZE_BYTE;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  chk_ready_after_req: assert property (tk |=> bus_rsp.ready)
    else $error("no answer one cycle after a request");
  chk_ready_has_cause: assert property (bus_rsp.ready |-> $past(tk))
    else $error("answer without a request");
  chk_byte_refused: assert property (tk && bus_req.size == PMCSR_SIZE_BYTE |=> bus_rsp.error)
    else $error("byte access not refused");
  chk_unmapped_err: assert property (tk && bus_req.addr == PMCSR_BASE_ADDR + 32'h8 |=> bus_rsp.error)
    else $error("unmapped address not refused");
  chk_clear_bits_zero: assert property (rd_ctl |=> bus_rsp.rdata[3:2] == 2'h0)
    else $error("flag clear bits read nonzero");
  chk_backup_gate: assert property (wr_ctl |-> ##2 power_ctl.backup_write_enable == $past(bus_req.wdata[8], 2))
    else $error("backup write gate wrong");
  chk_thr_follow: assert property (wr_ctl |-> ##2 power_ctl.detector_threshold_sel == $past(bus_req.wdata[7:5], 2))
    else $error("threshold select wrong");
  chk_det_en_follow: assert property (wr_ctl |-> ##2 (power_ctl.enter_standby
      || power_ctl.detector_enable == $past(bus_req.wdata[4], 2)))
    else $error("detector enable wrong");
  chk_pulldown_follow: assert property (wr_cs |-> ##2 wake_pin_pulldown == $past(bus_req.wdata[8], 2))
    else $error("pull-down not following wake enable");
  // mode register moves on the entry edge, the output flop one edge later
  chk_mode_entry: assert property (ce && core_deep_sleep_state && core_wfi
      && !power_ctl.enter_standby && !power_ctl.enter_deep_sleep
      |-> ##2 power_ctl.enter_standby != power_ctl.enter_deep_sleep)
    else $error("sleep entry did not pick one mode");
  chk_det_off_stby: assert property (power_ctl.enter_standby && $past(power_ctl.enter_standby) |-> !power_ctl.detector_enable)
    else $error("detector on in standby");
  chk_lp_deep_only: assert property (power_ctl.regulator_low_power |-> power_ctl.enter_deep_sleep)
    else $error("regulator low power outside deep-sleep");
  chk_reset_pulse: assert property ($rose(power_ctl.core_reset) |=> !power_ctl.core_reset)
    else $error("core reset longer than one cycle");
  cover property (power_ctl.enter_standby);
  cover property (power_ctl.enter_deep_sleep && power_ctl.regulator_low_power);
  cover property (bus_rsp.ready && bus_rsp.error);
endmodule : pmcsr_top_props

bind pmcsr_top pmcsr_top_props u_pmcsr_top_props (.ref_clk(ref_clk), .rst(rst), .ce(ce),
  .bus_req(bus_req), .bus_rsp(bus_rsp), .core_deep_sleep_state(core_deep_sleep_state),
  .core_wfi(core_wfi), .power_ctl(power_ctl), .wake_pin_pulldown(wake_pin_pulldown));

//--- verification/pmcsr_core_model.sv
// core model: bus master and deep-sleep signalling of the processor
`timescale 1ns/10ps
module pmcsr_core_model
  import pmcsr_pkg::*;
(
  // clock
  input  wire logic                      ref_clk,
  // register bus
  output pmcsr_pkg::pmcsr_bus_req_t      bus_req,
  input  wire pmcsr_pkg::pmcsr_bus_rsp_t bus_rsp,
  // sleep signalling
  output logic                           core_deep_sleep_state,
  output logic                           core_wfi
);
  initial begin
    bus_req = '0;
    core_deep_sleep_state = 1'b0;
    core_wfi = 1'b0;
  end
  // idle fields are inverted so a stale value is never mistaken for a request
  task automatic access(input logic wr, input logic [31:0] a, input logic [1:0] sz,
                        input logic [31:0] d, output pmcsr_bus_rsp_t rsp);
    int n;
    @(negedge ref_clk);
    bus_req = '{sel: 1'b1, write: wr, addr: a, size: sz, wdata: d};
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (bus_rsp.ready !== 1'b1 && n < 4);
    rsp = bus_rsp;
    bus_req = '{sel: 1'b0, write: ~wr, addr: ~a, size: ~sz, wdata: ~d};
  endtask : access
  task automatic sleep_now();
    @(negedge ref_clk);
    core_deep_sleep_state = 1'b1;
    core_wfi = 1'b1;
    @(negedge ref_clk);
    core_wfi = 1'b0;
  endtask : sleep_now
  task automatic leave_sleep();
    @(negedge ref_clk);
    core_deep_sleep_state = 1'b0;
  endtask : leave_sleep
endmodule : pmcsr_core_model

//--- verification/pmcsr_bench.sv
// bench: self-checking test of the power mode control/status registers
`timescale 1ns/10ps
module pmcsr_bench;
  import pmcsr_pkg::*;
  logic ref_clk, rst, ce, deep_sleep_wake, rtc_alarm, ext_wake_reset;
  logic low_voltage_detector, wake_pin, core_deep_sleep_state, core_wfi, wake_pin_pulldown;
  pmcsr_bus_req_t   bus_req;
  pmcsr_bus_rsp_t   bus_rsp, rsp;
  pmcsr_power_ctl_t power_ctl;
  int               err_total, checks_done, resets_seen;
  localparam logic [31:0] CTL = PMCSR_BASE_ADDR;
  localparam logic [31:0] CS = PMCSR_BASE_ADDR + 32'h4;
  localparam logic [1:0]  W = PMCSR_SIZE_WORD;
  localparam logic [1:0]  H = PMCSR_SIZE_HALF;
  localparam logic [1:0]  B = PMCSR_SIZE_BYTE;
  typedef struct packed {
    logic wr; logic [31:0] addr; logic [1:0] size; logic [31:0] wdata; logic err; logic [31:0] rdata;
  } pmcsr_row_t;
  // written control words keep reserved bit 14 at its reset value
  pmcsr_row_t rows [12] = '{
    '{1'b0, CTL, W, 32'h0, 1'b0, 32'h4000}, '{1'b0, CS, W, 32'h0, 1'b0, 32'h0},
    '{1'b1, CTL, W, 32'h41fc, 1'b0, 32'h0}, '{1'b0, CTL, W, 32'h0, 1'b0, 32'h41f0},
    '{1'b1, CTL, H, 32'h40a3, 1'b0, 32'h0}, '{1'b0, CTL, H, 32'h0, 1'b0, 32'h40a3},
    '{1'b0, CTL, B, 32'h0, 1'b1, 32'h0}, '{1'b0, CTL + 32'h8, W, 32'h0, 1'b1, 32'h0},
    '{1'b1, CTL, B, 32'h4100, 1'b1, 32'h0}, '{1'b0, CTL, W, 32'h0, 1'b0, 32'h40a3},
    '{1'b1, CS, H, 32'h100, 1'b0, 32'h0}, '{1'b0, CS, W, 32'h0, 1'b0, 32'h100}};

  pmcsr_top u_pmcsr_top (.ref_clk(ref_clk), .rst(rst), .ce(ce), .bus_req(bus_req),
    .bus_rsp(bus_rsp), .core_deep_sleep_state(core_deep_sleep_state), .core_wfi(core_wfi),
    .deep_sleep_wake(deep_sleep_wake), .rtc_alarm(rtc_alarm), .ext_wake_reset(ext_wake_reset),
    .low_voltage_detector(low_voltage_detector), .wake_pin(wake_pin), .power_ctl(power_ctl),
    .wake_pin_pulldown(wake_pin_pulldown));
  pmcsr_core_model u_pmcsr_core_model (.ref_clk(ref_clk), .bus_req(bus_req), .bus_rsp(bus_rsp),
    .core_deep_sleep_state(core_deep_sleep_state), .core_wfi(core_wfi));

  // ----------------------------------------------------------------
  // clock, helpers
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (power_ctl.core_reset === 1'b1) begin
      resets_seen++;
    end
  end
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("mismatches %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    u_pmcsr_core_model.access(wr, a, W, d, rsp);
    if (rsp.ready !== 1'b1) begin
      err_total++;
      end_sim();
    end
  endtask : xfer
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check({rsp.ready, rsp.error, rsp.rdata}, {2'h2, exp});
  endtask : rd
  // bounded wait for the sleep outputs to reach a level
  task automatic wait_mode(input logic want);
    int n;
    n = 0;
    while ((power_ctl.enter_standby | power_ctl.enter_deep_sleep) !== want && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 20) begin
      err_total++;
      end_sim();
    end
  endtask : wait_mode
  task automatic do_reset();
    @(negedge ref_clk);
    rst = 1'b1;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
  endtask : do_reset
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge ref_clk);
    s = 1'b0;
  endtask : pulse

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    err_total = 0;
    checks_done = 0;
    resets_seen = 0;
    rst = 1'b1;
    ce = 1'b1;
    deep_sleep_wake = 1'b0;
    rtc_alarm = 1'b0;
    ext_wake_reset = 1'b0;
    low_voltage_detector = 1'b0;
    wake_pin = 1'b0;
    do_reset();
    foreach (rows[i]) begin
      u_pmcsr_core_model.access(rows[i].wr, rows[i].addr, rows[i].size, rows[i].wdata, rsp);
      check({rsp.ready, rsp.error, rsp.rdata}, {1'b1, rows[i].err, rows[i].rdata});
    end
    for (int c = 0; c < 8; c++) begin
      xfer(1'b1, CTL, 32'h4110 | 32'(c << 5));
      repeat (2) @(negedge ref_clk);
      check(34'(power_ctl.detector_threshold_sel), 34'(c));
    end
    check({32'h0, power_ctl.backup_write_enable, power_ctl.detector_enable}, 34'h3);
    low_voltage_detector = 1'b1;
    repeat (8) @(negedge ref_clk);
    rd(CS, 32'h104);
    low_voltage_detector = 1'b0;
    repeat (8) @(negedge ref_clk);
    rd(CS, 32'h100);
    xfer(1'b1, CTL, 32'h4000);
    repeat (2) @(negedge ref_clk);
    check({32'h0, power_ctl.backup_write_enable, power_ctl.detector_enable}, 34'h0);
    wake_pin = 1'b1;
    repeat (8) @(negedge ref_clk);
    rd(CS, 32'h101);
    check(34'(wake_pin_pulldown), 34'h1);
    xfer(1'b1, CTL, 32'h4000);
    rd(CS, 32'h101);
    xfer(1'b1, CTL, 32'h4004);
    rd(CS, 32'h100);
    xfer(1'b1, CS, 32'h0);
    xfer(1'b1, CS, 32'h100);
    repeat (8) @(negedge ref_clk);
    rd(CS, 32'h101);
    xfer(1'b1, CTL, 32'h4004);
    wake_pin = 1'b0;
    // standby left by the alarm; detector enabled beforehand
    xfer(1'b1, CTL, 32'h4112);
    repeat (8) @(negedge ref_clk);
    u_pmcsr_core_model.sleep_now();
    wait_mode(1'b1);
    check({32'h0, power_ctl.enter_standby, power_ctl.detector_enable}, 34'h2);
    pulse(rtc_alarm);
    wait_mode(1'b0);
    u_pmcsr_core_model.leave_sleep();
    check(34'(resets_seen), 34'h1);
    rd(CTL, 32'h4000);
    rd(CS, 32'h103);
    xfer(1'b1, CTL, 32'h4004);
    rd(CS, 32'h102);
    xfer(1'b1, CTL, 32'h4008);
    rd(CS, 32'h100);
    // deep-sleep with regulator in low power
    xfer(1'b1, CTL, 32'h4001);
    u_pmcsr_core_model.sleep_now();
    wait_mode(1'b1);
    check({32'h0, power_ctl.enter_deep_sleep, power_ctl.regulator_low_power}, 34'h3);
    pulse(deep_sleep_wake);
    wait_mode(1'b0);
    u_pmcsr_core_model.leave_sleep();
    // standby left by a wake pin edge
    xfer(1'b1, CTL, 32'h4002);
    u_pmcsr_core_model.sleep_now();
    wait_mode(1'b1);
    wake_pin = 1'b1;
    wait_mode(1'b0);
    u_pmcsr_core_model.leave_sleep();
    rd(CS, 32'h103);
    // pin disabled: its edge must not wake; the reset pin leaves standby instead
    wake_pin = 1'b0;
    xfer(1'b1, CS, 32'h0);
    xfer(1'b1, CTL, 32'h400e);
    u_pmcsr_core_model.sleep_now();
    wait_mode(1'b1);
    wake_pin = 1'b1;
    repeat (8) @(negedge ref_clk);
    check(34'(power_ctl.enter_standby), 34'h1);
    pulse(ext_wake_reset);
    wait_mode(1'b0);
    u_pmcsr_core_model.leave_sleep();
    check(34'(resets_seen), 34'h3);
    rd(CS, 32'h2);
    check(34'(wake_pin_pulldown), 34'h0);
    do_reset();
    rd(CTL, 32'h4000);
    rd(CS, 32'h0);
    end_sim();
  end
endmodule : pmcsr_bench
